// >>> rtl/cwbc_config_decode.v
// Configuration word latch, decoder and register slave.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cwbc_regs.vh"

module cwbc_config_decode #(
    parameter ADDR_W = 12
) (
    // Clock and reset.
    input  wire                    clk,
    input  wire                    arst_n,
    // APB slave.
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [ADDR_W-1:0]       paddr,
    input  wire [31:0]             pwdata,
    output wire                    pready,
    output wire [31:0]             prdata,
    output wire                    pslverr,
    // Nonvolatile words as programmed.
    input  wire [23:0]             nv_boot_limit_word,
    input  wire [23:0]             nv_signature_word,
    input  wire [23:0]             nv_osc_select_word,
    input  wire [23:0]             nv_osc_config_word,
    input  wire [23:0]             nv_wd_config_word,
    // System conditions.
    input  wire                    sel_osc_ready,
    input  wire                    sys_clk_is_low_power_rc_osc,
    input  wire                    device_asleep,
    input  wire                    clock_out_signal,
    // Boot segment.
    output wire [12:0]             boot_segment_pages,
    output wire [12:0]             general_segment_first_page,
    // Clock generator settings.
    output reg  [2:0]              active_osc_src,
    output wire [2:0]              initial_osc_select,
    output wire                    two_speed_startup,
    output reg                     mult_none,
    output reg  [3:0]              mult_factor,
    output reg                     mult_usb,
    output reg  [5:0]              usb_input_mhz,
    output wire                    multiplier_enable_avail,
    output wire                    multiplier_source,
    output wire                    clock_switch_enable,
    output wire                    fail_safe_enable,
    output wire                    secondary_osc_crystal,
    output wire [1:0]              primary_osc_mode,
    output reg                     osc_out_pin_o,
    output reg                     osc_out_pin_oe,
    // Pin lock.
    output wire                    pin_map_lock,
    output wire                    pin_lock_once,
    // Watchdog settings.
    output reg  [1:0]              wd_clock_src,
    output reg  [2:0]              wd_window_eighths,
    output wire                    wd_window_enable,
    output reg                     wd_active,
    output wire [2:0]              wd_prescale_log2,
    output wire [3:0]              wd_postscale_log2,
    output wire                    cfg_loaded
);

    // Latched configuration words and load flag.
    reg  [23:0] boot_limit_ff;
    reg  [23:0] signature_ff;
    reg  [23:0] osc_select_ff;
    reg  [23:0] osc_config_ff;
    reg  [23:0] wd_config_ff;
    reg         loaded_ff;

    // Software state.
    reg         soft_wd_ff;
    reg         lock_ff;
    reg  [1:0]  unlock_ff;
    reg  [31:0] rdata_ff;
    reg         err_ff;

    // Named fields.
    wire [12:0] limit_inv;
    wire [3:0]  mult_sel;
    wire [1:0]  sw_mon;
    wire [1:0]  wd_clk_sel;
    wire        wd_mux_en;
    wire [1:0]  wd_win;
    wire        wd_win_dis;
    wire [1:0]  wd_en_cfg;

    // Bus decode.
    wire        setup_ph;
    wire        wr_acc;
    reg  [31:0] nxt_rdata;
    reg         nxt_err;
    reg  [2:0]  base_osc;

    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;

    // Words are caught once at the first edge after reset release and then frozen.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_limit_ff <= `CWBC_ERASED;
            signature_ff  <= `CWBC_ERASED;
            osc_select_ff <= `CWBC_ERASED;
            osc_config_ff <= `CWBC_ERASED;
            wd_config_ff  <= `CWBC_ERASED;
            loaded_ff     <= 1'b0;
        end else if (!loaded_ff) begin
            // Unimplemented positions are forced high; programmed bits pass as they are.
            boot_limit_ff <= nv_boot_limit_word | ~`CWBC_IMPL_BOOT_LIMIT;
            signature_ff  <= nv_signature_word  | ~`CWBC_IMPL_SIGNATURE;
            osc_select_ff <= nv_osc_select_word | ~`CWBC_IMPL_OSC_SELECT;
            osc_config_ff <= nv_osc_config_word | ~`CWBC_IMPL_OSC_CONFIG;
            wd_config_ff  <= nv_wd_config_word  | ~`CWBC_IMPL_WD_CONFIG;
            loaded_ff     <= 1'b1;
        end
    end

    assign cfg_loaded = loaded_ff;

    // Field extraction.
    assign limit_inv          = boot_limit_ff[12:0];
    assign two_speed_startup  = osc_select_ff[7];
    assign mult_sel           = osc_select_ff[6:3];
    assign initial_osc_select = osc_select_ff[2:0];
    assign sw_mon             = osc_config_ff[7:6];
    assign pin_lock_once      = osc_config_ff[5];
    assign multiplier_source  = osc_config_ff[4];
    assign secondary_osc_crystal = osc_config_ff[3];
    assign primary_osc_mode   = osc_config_ff[1:0];
    assign wd_clk_sel         = wd_config_ff[14:13];
    assign wd_mux_en          = wd_config_ff[11];
    assign wd_win             = wd_config_ff[9:8];
    assign wd_win_dis         = wd_config_ff[7];
    assign wd_en_cfg          = wd_config_ff[6:5];

    // The stored limit is inverted so that only growth is possible; erased gives zero.
    assign boot_segment_pages         = ~limit_inv;
    assign general_segment_first_page = ~limit_inv;

    // Switching and monitor enables.
    assign clock_switch_enable = ~sw_mon[1];
    assign fail_safe_enable    = ~sw_mon[1] & ~sw_mon[0];

    // Multiplier selection; undefined codes 1000..1011 behave as no multiplier.
    always @* begin
        mult_none     = 1'b0;
        mult_factor   = 4'h0;
        mult_usb      = 1'b0;
        usb_input_mhz = 6'h00;
        case (mult_sel)
            4'hE: mult_factor = 4'h8;
            4'hD: mult_factor = 4'h6;
            4'hC: mult_factor = 4'h4;
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                mult_usb = 1'b1;
                case (mult_sel[2:0])
                    3'h0: usb_input_mhz = 6'd4;
                    3'h1: usb_input_mhz = 6'd8;
                    3'h2: usb_input_mhz = 6'd12;
                    3'h3: usb_input_mhz = 6'd16;
                    3'h4: usb_input_mhz = 6'd20;
                    3'h5: usb_input_mhz = 6'd24;
                    3'h6: usb_input_mhz = 6'd32;
                    default: usb_input_mhz = 6'd48;
                endcase
            end
            default: mult_none = 1'b1;
        endcase
    end

    assign multiplier_enable_avail = ~mult_none;

    // Two-speed start holds the fast RC until the chosen source reports ready.
    always @* begin
        base_osc = initial_osc_select;
        if (two_speed_startup && !sel_osc_ready) begin
            base_osc = `CWBC_OSC_FRC;
        end
    end

    // Watchdog clock source.
    always @* begin
        wd_clock_src = `CWBC_WDCLK_LOW_POWER_RC_OSC;
        if (wd_mux_en) begin
            case (wd_clk_sel)
                2'h3: wd_clock_src = `CWBC_WDCLK_LOW_POWER_RC_OSC;
                2'h1: wd_clock_src = `CWBC_WDCLK_SECONDARY_OSC;
                2'h2: begin
                    if (!wd_win_dis && !sys_clk_is_low_power_rc_osc && !device_asleep) begin
                        wd_clock_src = `CWBC_WDCLK_FRC;
                    end
                end
                default: begin
                    if (!sys_clk_is_low_power_rc_osc && !device_asleep) begin
                        wd_clock_src = `CWBC_WDCLK_PERIPH;
                    end else begin
                        wd_clock_src = `CWBC_WDCLK_LOW_POWER_RC_OSC;
                    end
                end
            endcase
        end
    end

    // Window width in eighths of the period.
    always @* begin
        case (wd_win)
            2'h3: wd_window_eighths = 3'd2;
            2'h2: wd_window_eighths = 3'd3;
            2'h1: wd_window_eighths = 3'd4;
            default: wd_window_eighths = 3'd6;
        endcase
    end

    assign wd_window_enable  = ~wd_win_dis;
    assign wd_prescale_log2  = wd_config_ff[4] ? `CWBC_PRE_LOG2_HIGH : `CWBC_PRE_LOG2_LOW;
    assign wd_postscale_log2 = wd_config_ff[3:0];

    // Watchdog run state from the enable field, software bit and sleep.
    always @* begin
        case (wd_en_cfg)
            2'h3: wd_active = 1'b1;
            2'h2: wd_active = soft_wd_ff;
            2'h1: wd_active = ~device_asleep;
            default: wd_active = 1'b0;
        endcase
    end

    // Start source and clock-out pin outputs are registered.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_osc_src <= `CWBC_OSC_FRC;
            osc_out_pin_o  <= 1'b0;
            osc_out_pin_oe <= 1'b0;
        end else begin
            active_osc_src <= base_osc;
            if (osc_config_ff[2] && (primary_osc_mode == `CWBC_POSC_OFF ||
                                     primary_osc_mode == `CWBC_POSC_EXT)) begin
                osc_out_pin_o  <= clock_out_signal;
                osc_out_pin_oe <= 1'b1;
            end else begin
                osc_out_pin_o  <= 1'b0;
                osc_out_pin_oe <= 1'b0;
            end
        end
    end

    // Soft enable, unlock sequence and pin lock.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_wd_ff <= 1'b0;
            lock_ff    <= 1'b0;
            unlock_ff  <= 2'b00;
        end else if (wr_acc) begin
            if (paddr == `CWBC_OFF_UNLOCK) begin
                if (pwdata == `CWBC_UNLOCK_KEY1) begin
                    unlock_ff <= 2'b01;
                end else if (pwdata == `CWBC_UNLOCK_KEY2 && unlock_ff == 2'b01) begin
                    unlock_ff <= 2'b10;
                end else begin
                    unlock_ff <= 2'b00;
                end
            end else if (paddr == `CWBC_OFF_CONTROL) begin
                // Soft enable is only honoured when the enable field hands it over.
                soft_wd_ff <= (wd_en_cfg == 2'h2) & pwdata[`CWBC_CTL_SOFT_WD];
                if (unlock_ff == 2'b10) begin
                    if (pwdata[`CWBC_CTL_PIN_LOCK]) begin
                        lock_ff <= 1'b1;
                    end else if (!pin_lock_once) begin
                        lock_ff <= 1'b0;
                    end
                end
                unlock_ff <= 2'b00;
            end else begin
                unlock_ff <= 2'b00;
            end
        end
    end

    assign pin_map_lock = lock_ff;

    // Read data and error are prepared in the setup phase.
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err   = 1'b0;
        case (paddr)
            `CWBC_OFF_BOOT_LIMIT: nxt_rdata = {8'h00, boot_limit_ff};
            `CWBC_OFF_SIGNATURE:  nxt_rdata = {8'h00, signature_ff};
            `CWBC_OFF_OSC_SELECT: nxt_rdata = {8'h00, osc_select_ff};
            `CWBC_OFF_OSC_CONFIG: nxt_rdata = {8'h00, osc_config_ff};
            `CWBC_OFF_WD_CONFIG:  nxt_rdata = {8'h00, wd_config_ff};
            `CWBC_OFF_CONTROL:    nxt_rdata = {30'h00000000, lock_ff, soft_wd_ff};
            `CWBC_OFF_STATUS:     nxt_rdata = {24'h000000, wd_active, active_osc_src,
                                               unlock_ff, lock_ff, loaded_ff};
            `CWBC_OFF_UNLOCK:     nxt_rdata = 32'h00000000;
            default:              nxt_err   = 1'b1;
        endcase
    end

    // Bus answer registers.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 32'h00000000;
            err_ff   <= 1'b0;
        end else if (setup_ph) begin
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = rdata_ff;
    assign pslverr = psel & penable & err_ff;

endmodule
`default_nettype wire

// >>> pkg/cwbc_regs.vh
// Register map, field positions and reset values of the configuration decoder.
`ifndef CWBC_REGS_VH
`define CWBC_REGS_VH

// Byte offsets on the register bus.
`define CWBC_OFF_BOOT_LIMIT  12'h000
`define CWBC_OFF_SIGNATURE   12'h004
`define CWBC_OFF_OSC_SELECT  12'h008
`define CWBC_OFF_OSC_CONFIG  12'h00C
`define CWBC_OFF_WD_CONFIG   12'h010
`define CWBC_OFF_CONTROL     12'h014
`define CWBC_OFF_STATUS      12'h018
`define CWBC_OFF_UNLOCK      12'h01C

// Word width, erased value and masks of implemented bits.
`define CWBC_WORD_W          24
`define CWBC_ERASED          24'hFFFFFF
`define CWBC_IMPL_BOOT_LIMIT 24'h001FFF
`define CWBC_IMPL_SIGNATURE  24'h008000
`define CWBC_IMPL_OSC_SELECT 24'h0003FF
`define CWBC_IMPL_OSC_CONFIG 24'h0000FF
`define CWBC_IMPL_WD_CONFIG  24'h006BFF

// Control register fields and unlock keys.
`define CWBC_CTL_SOFT_WD     0
`define CWBC_CTL_PIN_LOCK    1
`define CWBC_UNLOCK_KEY1     32'h000000A5
`define CWBC_UNLOCK_KEY2     32'h0000005A

// Oscillator source codes.
`define CWBC_OSC_FRC         3'h0
`define CWBC_OSC_FRC_MULT    3'h1
`define CWBC_OSC_PRIMARY     3'h2
`define CWBC_OSC_PRI_MULT    3'h3
`define CWBC_OSC_SECONDARY   3'h4
`define CWBC_OSC_LOW_POWER_RC_OSC        3'h5
`define CWBC_OSC_DCO         3'h6
`define CWBC_OSC_DIVIDED     3'h7

// Primary oscillator modes.
`define CWBC_POSC_OFF        2'h3
`define CWBC_POSC_HIGH       2'h2
`define CWBC_POSC_LOW        2'h1
`define CWBC_POSC_EXT        2'h0

// Watchdog clock source codes presented to the watchdog.
`define CWBC_WDCLK_LOW_POWER_RC_OSC      2'h0
`define CWBC_WDCLK_SECONDARY_OSC      2'h1
`define CWBC_WDCLK_FRC       2'h2
`define CWBC_WDCLK_PERIPH    2'h3

// Prescaler ratios as powers of two.
`define CWBC_PRE_LOG2_HIGH   3'h7
`define CWBC_PRE_LOG2_LOW    3'h5

`endif

// >>> tb/cwbc_config_decode_properties.sv
// Concurrent checks on the ports of the configuration decoder.
`timescale 1ns/1ps
`default_nettype none
module cwbc_checker (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        arst_n,
    // System conditions.
    input wire logic        clock_out_signal,
    input wire logic        sel_osc_ready,
    input wire logic        sys_clk_is_low_power_rc_osc,
    input wire logic        device_asleep,
    input wire logic [23:0] nv_boot_limit_word,
    // Decoded settings.
    input wire logic [12:0] boot_segment_pages,
    input wire logic [12:0] general_segment_first_page,
    input wire logic [2:0]  active_osc_src,
    input wire logic [2:0]  initial_osc_select,
    input wire logic        two_speed_startup,
    input wire logic        clock_switch_enable,
    input wire logic        fail_safe_enable,
    input wire logic [1:0]  primary_osc_mode,
    input wire logic        osc_out_pin_o,
    input wire logic        osc_out_pin_oe,
    input wire logic        pin_map_lock,
    input wire logic        pin_lock_once,
    input wire logic [1:0]  wd_clock_src,
    input wire logic        wd_window_enable,
    input wire logic        cfg_loaded
);
    // All checks sample on the rising edge and rest while reset is low.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Boot segment end and general segment start are the same page.
    property p_seg; boot_segment_pages == general_segment_first_page; endproperty
    a_seg: assert property (p_seg) else $error("segment pages differ");
    // The first latched limit is the inverse of the programmed field, unused bits high.
    property p_lim; $rose(cfg_loaded) |->
        {11'h7FF, ~boot_segment_pages} == ($past(nv_boot_limit_word) | 24'hFFE000);
    endproperty
    a_lim: assert property (p_lim) else $error("boot limit not inverted");
    // Latched settings never move once loaded.
    property p_hold; cfg_loaded && $past(cfg_loaded) |-> $stable(boot_segment_pages) && $stable(initial_osc_select);
    endproperty
    a_hold: assert property (p_hold) else $error("latched setting moved");
    // With two-speed start, fast RC runs until the selected source is ready; without it the selected source starts directly.
    property p_tss; cfg_loaded && two_speed_startup && !sel_osc_ready |=> active_osc_src == 3'h0; endproperty
    a_tss: assert property (p_tss) else $error("start source not fast RC");
    property p_dir; cfg_loaded && !two_speed_startup |=> active_osc_src == initial_osc_select; endproperty
    a_dir: assert property (p_dir) else $error("start source not selected one");
    // The monitor never runs without clock switching.
    property p_mon; fail_safe_enable |-> clock_switch_enable; endproperty
    a_mon: assert property (p_mon) else $error("monitor without switching");
    // Clock out only with the primary off or external; the enable is registered one cycle behind.
    property p_oe; osc_out_pin_oe |-> $past(primary_osc_mode) == 2'h3 || $past(primary_osc_mode) == 2'h0;
    endproperty
    a_oe: assert property (p_oe) else $error("clock out in crystal mode");
    property p_copy; osc_out_pin_oe && $past(osc_out_pin_oe) |-> osc_out_pin_o == $past(clock_out_signal);
    endproperty
    a_copy: assert property (p_copy) else $error("clock out not copied");
    // A one-time lock is never cleared.
    property p_once; cfg_loaded && pin_lock_once && $past(pin_map_lock) |-> pin_map_lock; endproperty
    a_once: assert property (p_once) else $error("one-time lock cleared");
    // Fast RC and peripheral clocks need an awake device not on low-power RC.
    property p_frc; wd_clock_src == 2'h2 |-> wd_window_enable && !sys_clk_is_low_power_rc_osc && !device_asleep; endproperty
    a_frc: assert property (p_frc) else $error("watchdog fast RC misused");
    property p_per; wd_clock_src == 2'h3 |-> !sys_clk_is_low_power_rc_osc && !device_asleep; endproperty
    a_per: assert property (p_per) else $error("watchdog peripheral clock misused");
endmodule
bind cwbc_config_decode cwbc_checker u_chk (.*);
`default_nettype wire

// >>> tb/cwbc_far_side.sv
// Clock generator stand-in: oscillator ready flag and clock to copy out.
`timescale 1ns/1ps
`default_nettype none
module cwbc_far_side #(
    parameter int READY_DLY = 8
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic arst_n,
    // Toward the decoder.
    output var logic  sel_osc_ready,
    output var logic  clock_out_signal
);
    int cnt_ff;
    // The selected source becomes ready some cycles after reset, so start-up is seen slow.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 0;
            clock_out_signal <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff < READY_DLY) ? cnt_ff + 1 : cnt_ff;
            clock_out_signal <= ~clock_out_signal;
        end
    end
    assign sel_osc_ready = (cnt_ff >= READY_DLY);
endmodule
`default_nettype wire

// >>> tb/clock_wdt_boot_config_decode_tb.sv
// Self-checking bench for the configuration decoder.
`timescale 1ns/1ps
`default_nettype none
`include "cwbc_regs.vh"
module clock_wdt_boot_config_decode_tb;
    logic clk, arst_n, psel, penable, pwrite, sys_clk_is_low_power_rc_osc, device_asleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    logic e;
    logic [23:0] nv_boot_limit_word, nv_signature_word, nv_osc_select_word, nv_osc_config_word, nv_wd_config_word;
    wire pready, pslverr, sel_osc_ready, clock_out_signal, two_speed_startup, mult_none, mult_usb, cfg_loaded;
    wire multiplier_enable_avail, multiplier_source, clock_switch_enable, fail_safe_enable, secondary_osc_crystal;
    wire osc_out_pin_o, osc_out_pin_oe, pin_map_lock, pin_lock_once, wd_window_enable, wd_active;
    wire [31:0] prdata;
    wire [12:0] boot_segment_pages, general_segment_first_page;
    wire [2:0] active_osc_src, initial_osc_select, wd_window_eighths, wd_prescale_log2;
    wire [3:0] mult_factor, wd_postscale_log2;
    wire [5:0] usb_input_mhz;
    wire [1:0] primary_osc_mode, wd_clock_src;
    int fail_count = 0;
    int checked = 0;
    localparam logic [2:0] WIN8 [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
    localparam logic [1:0] WCLK [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    localparam logic [3:0] MULT [3] = '{4'h4, 4'h6, 4'h8};

    cwbc_config_decode dut (.*);
    cwbc_far_side u_far (.clk(clk), .arst_n(arst_n), .sel_osc_ready(sel_osc_ready), .clock_out_signal(clock_out_signal));

    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            rdy = pready;
            if (rdy === 1'b1) begin
                q = prdata;
                e = pslverr;
                break;
            end
        end
        if (n >= 50) begin fail_count++; tally_and_finish(); end
        psel <= 1'b0; penable <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("read data", q, exp);
    endtask

    // Unlock keys followed by a control write.
    task automatic ctl(input logic [31:0] d);
        apb(1'b1, `CWBC_OFF_UNLOCK, `CWBC_UNLOCK_KEY1);
        apb(1'b1, `CWBC_OFF_UNLOCK, `CWBC_UNLOCK_KEY2);
        apb(1'b1, `CWBC_OFF_CONTROL, d);
    endtask

    // Program the words, then reset for 3 cycles so they are latched.
    task automatic boot(input logic [23:0] b, s, os, oc, wd);
        @(posedge clk);
        nv_boot_limit_word <= b; nv_signature_word <= s; nv_osc_select_word <= os;
        nv_osc_config_word <= oc; nv_wd_config_word <= wd;
        sys_clk_is_low_power_rc_osc <= 1'b0; device_asleep <= 1'b0; arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // Hang guard.
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        arst_n = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        sys_clk_is_low_power_rc_osc = 1'b0; device_asleep = 1'b0;
        nv_boot_limit_word = `CWBC_ERASED; nv_signature_word = `CWBC_ERASED; nv_osc_select_word = `CWBC_ERASED;
        nv_osc_config_word = `CWBC_ERASED; nv_wd_config_word = `CWBC_ERASED;
        boot(`CWBC_ERASED, `CWBC_ERASED, `CWBC_ERASED, `CWBC_ERASED, `CWBC_ERASED);
        chk("boot pages", boot_segment_pages, 32'h0);
        chk("no multiplier", mult_none, 32'h1);
        chk("wd active", wd_active, 32'h1);
        chk("start source", active_osc_src, `CWBC_OSC_FRC);
        rd(`CWBC_OFF_BOOT_LIMIT, 32'h00FFFFFF);
        $display("test erased done");

        // Primary as a 16 MHz USB multiplier input and multiplier fed from fast RC here.
        boot(24'hFFFFF0, `CWBC_ERASED, 24'h00001A, 24'h000000, 24'h004845);
        chk("boot pages", boot_segment_pages, 32'h000F);
        chk("general start", general_segment_first_page, 32'h000F);
        rd(`CWBC_OFF_OSC_SELECT, 32'h00FFFC1A);
        rd(`CWBC_OFF_WD_CONFIG, 32'h00FFDC45);
        apb(1'b1, `CWBC_OFF_BOOT_LIMIT, 32'h0);
        rd(`CWBC_OFF_BOOT_LIMIT, 32'h00FFFFF0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", e, 32'h1);
        chk("unmapped data", q, 32'h0);
        @(posedge clk);
        nv_boot_limit_word <= 24'h000000;
        repeat (3) @(negedge clk);
        chk("boot held", boot_segment_pages, 32'h000F);
        chk("usb mult", mult_usb, 32'h1);
        chk("usb input", usb_input_mhz, 32'd16);
        chk("direct start", active_osc_src, `CWBC_OSC_PRIMARY);
        chk("monitor", fail_safe_enable, 32'h1);
        chk("mult from fast rc", multiplier_source, 32'h0);
        chk("secondary_osc digital", secondary_osc_crystal, 32'h0);
        chk("clock out off", osc_out_pin_oe, 32'h0);
        chk("wd window", wd_window_enable, 32'h1);
        chk("wd prescale", wd_prescale_log2, `CWBC_PRE_LOG2_LOW);
        chk("wd postscale", wd_postscale_log2, 32'h5);
        chk("wd soft off", wd_active, 32'h0);
        @(posedge clk);
        sys_clk_is_low_power_rc_osc <= 1'b1;
        @(negedge clk);
        chk("wd fallback", wd_clock_src, `CWBC_WDCLK_LOW_POWER_RC_OSC);
        apb(1'b1, `CWBC_OFF_CONTROL, 32'h3);
        chk("soft wd on", wd_active, 32'h1);
        chk("lock needs keys", pin_map_lock, 32'h0);
        ctl(32'h3);
        chk("lock set", pin_map_lock, 32'h1);
        ctl(32'h1);
        chk("lock cleared", pin_map_lock, 32'h0);
        $display("test programmed done");

        boot(`CWBC_ERASED, 24'hFF7FFF, 24'h0000F3, 24'h00007C, 24'h000BBF);
        chk("two speed", active_osc_src, `CWBC_OSC_FRC);
        rd(`CWBC_OFF_SIGNATURE, 32'h00FF7FFF);
        repeat (10) @(negedge clk);
        chk("switched", active_osc_src, `CWBC_OSC_PRI_MULT);
        chk("mult from primary", multiplier_source, 32'h1);
        chk("secondary_osc crystal", secondary_osc_crystal, 32'h1);
        chk("lock once", pin_lock_once, 32'h1);
        chk("clock out on", osc_out_pin_oe, 32'h1);
        chk("wd periph", wd_clock_src, `CWBC_WDCLK_PERIPH);
        chk("wd awake", wd_active, 32'h1);
        ctl(32'h2);
        ctl(32'h0);
        chk("lock kept", pin_map_lock, 32'h1);
        @(posedge clk);
        device_asleep <= 1'b1;
        @(negedge clk);
        chk("wd sleep", wd_active, 32'h0);
        chk("wd sleep clock", wd_clock_src, `CWBC_WDCLK_LOW_POWER_RC_OSC);
        $display("test lock once done");

        // Walk the two-bit codes of every field together.
        for (int i = 0; i < 4; i++) begin
            boot(`CWBC_ERASED, `CWBC_ERASED, 24'((12 + i) << 3 | i), 24'(i << 6 | 4 | i),
                 24'(i << 13 | 24'h800 | i << 8 | i << 5 | (i % 2) << 4 | i));
            chk("window width", wd_window_eighths, WIN8[i]);
            chk("wd clock", wd_clock_src, WCLK[i]);
            chk("wd enable", wd_active, (i % 2));
            chk("primary mode", primary_osc_mode, i);
            chk("clock out", osc_out_pin_oe, (i == 0 || i == 3));
            chk("switching", clock_switch_enable, (i < 2));
            chk("no multiplier", mult_none, (i == 3));
            chk("mult enable avail", multiplier_enable_avail, (i != 3));
            chk("initial osc", initial_osc_select, i);
            if (i < 3) chk("mult factor", mult_factor, MULT[i]);
        end
        $display("test code walk done");

        // Clock select says secondary, but with the mux off the watchdog stays on low-power RC.
        boot(`CWBC_ERASED, `CWBC_ERASED, `CWBC_ERASED, `CWBC_ERASED, 24'h0023FF);
        chk("wd mux off", wd_clock_src, `CWBC_WDCLK_LOW_POWER_RC_OSC);
        $display("test mux off done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
